// *** design/fsp_pkg.sv ***
// Package: constants and types of the flash self-programming controller
package fsp_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [7:0]  FSP_CTRL_OFS    = 8'h00;
  localparam logic [7:0]  FSP_PTR_OFS     = 8'h04;
  localparam logic [7:0]  FSP_DATA_OFS    = 8'h08;
  localparam logic [7:0]  FSP_STAT_OFS    = 8'h0C;

  // ==========================================================================
  // Control field layout
  localparam int          FSP_CMD_W       = 5;
  localparam int          FSP_EN_BIT      = 0;
  localparam int          FSP_STAT_BUSY   = 0;
  localparam int          FSP_STAT_STALL  = 1;
  localparam int          FSP_STAT_OPEN   = 2;
  localparam int          FSP_STAT_PAGE   = 16;

  // ==========================================================================
  // Command patterns of the low five control bits: the five accepted ones plus the cleared value
  localparam logic [4:0]  FSP_CMD_FILL    = 5'h01;
  localparam logic [4:0]  FSP_CMD_ERASE   = 5'h03;
  localparam logic [4:0]  FSP_CMD_WRITE   = 5'h05;
  localparam logic [4:0]  FSP_CMD_LOCK    = 5'h09;
  localparam logic [4:0]  FSP_CMD_RWW     = 5'h11;
  localparam logic [4:0]  FSP_CMD_NONE    = 5'h00;

  // ==========================================================================
  // Reset values and counts
  localparam logic [15:0] FSP_PTR_RST     = 16'h0000;
  localparam logic [15:0] FSP_DATA_RST    = 16'h0000;
  localparam int          FSP_WIN_W       = 3;
  localparam logic [2:0]  FSP_WIN_CYCLES  = 3'h4;

  // ==========================================================================
  // Bus answers
  localparam logic [1:0]  FSP_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  FSP_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0]
  {
    FSP_IDLE  = 2'h0,
    FSP_ARMED = 2'h1,
    FSP_BUSY  = 2'h3
  } fsp_state_t;

endpackage

// *** design/fsp_cycle_window.sv ***
// Down-counting window that stays open for a loaded number of cycles
`timescale 1ns/10ps
module fsp_cycle_window #(
  parameter int W = 3
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         stop,
  // Status
  output logic              open,
  output logic              expire
);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  wire          cnt_last = (cnt_ff == W'(1));

  assign open   = (cnt_ff != '0);
  assign expire = cnt_last && !load && !stop;
  assign nxt_cnt = load ? load_val : (stop || !open) ? '0 : cnt_ff - W'(1);

  always_ff @(posedge clk)
  begin
    if (rst)
      cnt_ff <= '0;
    else
      cnt_ff <= nxt_cnt;
  end

endmodule

// *** design/fsp_page_buf.sv ***
// Temporary page buffer: one write port, one read port with registered data
`timescale 1ns/10ps
module fsp_page_buf #(
  parameter int AW = 6,
  parameter int DW = 16
) (
  // Clock
  input  wire logic          clk,
  // Write port
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_idx,
  input  wire logic [DW-1:0] wr_data,
  // Read port
  input  wire logic [AW-1:0] rd_idx,
  output logic      [DW-1:0] rd_data_ff
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem[wr_idx] <= wr_data;
    rd_data_ff <= mem[rd_idx];
  end

endmodule

// *** design/fsp_ctrl.sv ***
// Flash self-programming controller with AXI4-Lite register access
//
// Operation
// - Enable plus page-write arms a page write from the page buffer for the next store within four cycles.
// - Page erase and page write take the page from the pointer's upper bits and ignore the data pair.
// - The page-write bit clears when the write finishes or when no store comes within four cycles.
// - A page in the no-read-while-write section stalls the core for the whole erase or write.
// - Enable plus page-erase arms an erase of the addressed page for the next store within four cycles.
// - The page-erase bit clears when the erase completes or when no store comes within four cycles.
// - Setting enable opens stores for four cycles only; later stores do nothing until armed again.
// - Enable alone makes a store write the data pair into the buffer word picked by the pointer, bit 0 ignored.
// - Enable clears after a store or a four-cycle timeout but stays set through an erase or write.
// - Only the five patterns 10001, 01001, 00101, 00011 and 00001 take effect; others are ignored.
// - The pointer's low bits pick a word within a page and its high bits pick the page.
// - The target page is latched when an operation starts, so later pointer writes do not disturb it.
// - Setting the boot lock bits ignores the pointer entirely.
// - A load reads flash byte by byte, pointer bit 0 choosing the high or low byte.
`timescale 1ns/10ps
module fsp_ctrl
  import fsp_pkg::*;
#(
  parameter int          PAGE_WORD_BITS = 6,
  parameter int          PAGE_WORDS     = 64,
  parameter logic [15:0] NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 16'h0070
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst,
  // AXI4-Lite write address
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  input  wire logic [7:0]                s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  // AXI4-Lite write response
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  output logic      [1:0]                s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  input  wire logic [7:0]                s_axi_araddr,
  // AXI4-Lite read data
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  output logic      [31:0]               s_axi_rdata,
  output logic      [1:0]                s_axi_rresp,
  // Core instruction side
  input  wire logic                      store_program_instruction,
  input  wire logic                      load_program_instruction,
  output logic                           cpu_stall,
  output logic      [7:0]                load_data,
  output logic                           load_valid,
  // Flash array side
  output logic                           flash_op_start,
  output logic                           flash_op_erase,
  output logic      [15-PAGE_WORD_BITS-1:0] flash_page_addr,
  input  wire logic                      flash_op_done,
  input  wire logic [PAGE_WORD_BITS-1:0] flash_buf_idx,
  output logic      [15:0]               flash_buf_data,
  output logic      [14:0]               flash_rd_addr,
  input  wire logic [15:0]               flash_rd_data,
  // Lock bits and section re-enable
  output logic                           boot_lock_bit_set,
  output logic      [7:0]                boot_lock_value,
  output logic                           rww_section_read_reenable
);

  localparam int PG_W = 15 - PAGE_WORD_BITS;

  // ==========================================================================
  // Registers
  fsp_state_t        state_ff;
  fsp_state_t        nxt_state;
  logic [4:0]        cmd_ff;
  logic [4:0]        nxt_cmd;
  logic [15:0]       address_pointer_ff;
  logic [15:0]       store_data_register_pair_ff;
  logic [PG_W-1:0]   page_ff;
  logic              erase_ff;
  logic              start_ff;
  logic              lock_set_ff;
  logic [7:0]        lock_value_ff;
  logic              rww_ff;
  logic [14:0]       rd_addr_ff;
  logic              byte_sel_ff;
  logic              load_pend_ff;
  logic [7:0]        load_data_ff;
  logic              load_valid_ff;

  // ==========================================================================
  // AXI4-Lite slave
  logic              aw_got_ff;
  logic [7:0]        aw_addr_ff;
  logic              w_got_ff;
  logic [31:0]       w_data_ff;
  logic [3:0]        w_strb_ff;
  logic              bvalid_ff;
  logic [1:0]        bresp_ff;
  logic              rvalid_ff;
  logic [31:0]       rdata_ff;
  logic [1:0]        rresp_ff;

  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready  = !w_got_ff && !bvalid_ff;
  assign s_axi_bvalid  = bvalid_ff;
  assign s_axi_bresp   = bresp_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_rvalid  = rvalid_ff;
  assign s_axi_rdata   = rdata_ff;
  assign s_axi_rresp   = rresp_ff;

  wire aw_take = s_axi_awvalid && s_axi_awready;
  wire w_take  = s_axi_wvalid && s_axi_wready;
  wire ar_take = s_axi_arvalid && s_axi_arready;

  // Address and data may arrive in either order; commit once both are held
  wire        wr_commit = aw_got_ff && w_got_ff && !bvalid_ff;
  wire        wr_ctrl   = wr_commit && (aw_addr_ff == FSP_CTRL_OFS);
  wire        wr_ptr    = wr_commit && (aw_addr_ff == FSP_PTR_OFS);
  wire        wr_data   = wr_commit && (aw_addr_ff == FSP_DATA_OFS);
  wire        wr_stat   = wr_commit && (aw_addr_ff == FSP_STAT_OFS);
  wire        wr_hit    = wr_ctrl || wr_ptr || wr_data || wr_stat;

  wire [15:0] ptr_merged  = {w_strb_ff[1] ? w_data_ff[15:8] : address_pointer_ff[15:8],
                             w_strb_ff[0] ? w_data_ff[7:0]  : address_pointer_ff[7:0]};
  wire [15:0] data_merged = {w_strb_ff[1] ? w_data_ff[15:8] : store_data_register_pair_ff[15:8],
                             w_strb_ff[0] ? w_data_ff[7:0]  : store_data_register_pair_ff[7:0]};

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      aw_got_ff  <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_got_ff   <= 1'b0;
      w_data_ff  <= 32'h0000_0000;
      w_strb_ff  <= 4'h0;
      bvalid_ff  <= 1'b0;
      bresp_ff   <= FSP_RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_got_ff  <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_got_ff  <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
      end
      if (wr_commit)
      begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff  <= wr_hit ? FSP_RESP_OKAY : FSP_RESP_SLVERR;
      end
      else if (bvalid_ff && s_axi_bready)
        bvalid_ff <= 1'b0;
    end
  end

  // ==========================================================================
  // Read decode
  wire [31:0] stat_word = {{(16-PG_W){1'b0}}, page_ff, 13'h0000,
                           (state_ff == FSP_ARMED), cpu_stall, (state_ff == FSP_BUSY)};
  wire        rd_ctrl   = (s_axi_araddr == FSP_CTRL_OFS);
  wire        rd_ptr    = (s_axi_araddr == FSP_PTR_OFS);
  wire        rd_data   = (s_axi_araddr == FSP_DATA_OFS);
  wire        rd_stat   = (s_axi_araddr == FSP_STAT_OFS);
  wire        rd_hit    = rd_ctrl || rd_ptr || rd_data || rd_stat;
  wire [31:0] rd_word   = rd_ctrl ? {27'h000_0000, cmd_ff} :
                          rd_ptr  ? {16'h0000, address_pointer_ff} :
                          rd_data ? {16'h0000, store_data_register_pair_ff} :
                          rd_stat ? stat_word : 32'h0000_0000;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h0000_0000;
      rresp_ff  <= FSP_RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_word;
      rresp_ff  <= rd_hit ? FSP_RESP_OKAY : FSP_RESP_SLVERR;
    end
    else if (rvalid_ff && s_axi_rready)
      rvalid_ff <= 1'b0;
  end

  // ==========================================================================
  // Pointer and data pair
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      address_pointer_ff          <= FSP_PTR_RST;
      store_data_register_pair_ff <= FSP_DATA_RST;
    end
    else
    begin
      if (wr_ptr)
        address_pointer_ff <= ptr_merged;
      if (wr_data)
        store_data_register_pair_ff <= data_merged;
    end
  end

  // ==========================================================================
  // Command arming and the four-cycle window
  wire [4:0] wr_pattern = w_data_ff[FSP_CMD_W-1:0];
  wire       pattern_ok = (wr_pattern == FSP_CMD_FILL) || (wr_pattern == FSP_CMD_ERASE) ||
                          (wr_pattern == FSP_CMD_WRITE) || (wr_pattern == FSP_CMD_LOCK) ||
                          (wr_pattern == FSP_CMD_RWW);
  // Arming while an erase or write runs is dropped: the array is not free
  wire       arm        = wr_ctrl && w_strb_ff[0] && pattern_ok && (state_ff != FSP_BUSY);
  wire       win_open;
  wire       win_expire;
  wire       spm_go     = store_program_instruction && win_open &&
                          (state_ff == FSP_ARMED) && !arm;

  fsp_cycle_window #(
    .W        (FSP_WIN_W)
  ) u_window (
    .clk      (clk),
    .rst      (rst),
    .load     (arm),
    .load_val (FSP_WIN_CYCLES),
    .stop     (spm_go),
    .open     (win_open),
    .expire   (win_expire)
  );

  // Word-in-page from the low bits, page from the high bits, bit 0 ignored
  wire [PAGE_WORD_BITS-1:0] ptr_word = address_pointer_ff[PAGE_WORD_BITS:1];
  wire [PG_W-1:0]           ptr_page = address_pointer_ff[15:PAGE_WORD_BITS+1];

  wire is_fill  = (cmd_ff == FSP_CMD_FILL);
  wire is_erase = (cmd_ff == FSP_CMD_ERASE);
  wire is_write = (cmd_ff == FSP_CMD_WRITE);
  wire is_lock  = (cmd_ff == FSP_CMD_LOCK);
  wire is_rww   = (cmd_ff == FSP_CMD_RWW);
  wire buf_we   = spm_go && is_fill;
  wire op_go    = spm_go && (is_erase || is_write);

  always_comb
  begin
    nxt_state = state_ff;
    nxt_cmd   = cmd_ff;
    case (state_ff)
      FSP_IDLE:
      begin
        if (arm)
        begin
          nxt_state = FSP_ARMED;
          nxt_cmd   = wr_pattern;
        end
      end
      FSP_ARMED:
      begin
        if (arm)
          nxt_cmd = wr_pattern;
        else if (op_go)
          nxt_state = FSP_BUSY;
        else if (spm_go || win_expire)
        begin
          nxt_state = FSP_IDLE;
          nxt_cmd   = FSP_CMD_NONE;
        end
      end
      FSP_BUSY:
      begin
        // Enable and request bits stay up until the array reports done
        if (flash_op_done)
        begin
          nxt_state = FSP_IDLE;
          nxt_cmd   = FSP_CMD_NONE;
        end
      end
      default:
      begin
        nxt_state = FSP_IDLE;
        nxt_cmd   = FSP_CMD_NONE;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_ff <= FSP_IDLE;
      cmd_ff   <= FSP_CMD_NONE;
    end
    else
    begin
      state_ff <= nxt_state;
      cmd_ff   <= nxt_cmd;
    end
  end

  // ==========================================================================
  // Operation launch: page latched at start, data pair used only for the lock value
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      page_ff     <= '0;
      erase_ff    <= 1'b0;
      start_ff    <= 1'b0;
      lock_set_ff   <= 1'b0;
      lock_value_ff <= 8'h00;
      rww_ff        <= 1'b0;
    end
    else
    begin
      start_ff    <= op_go;
      lock_set_ff <= spm_go && is_lock;
      rww_ff      <= spm_go && is_rww;
      if (op_go)
      begin
        page_ff  <= ptr_page;
        erase_ff <= is_erase;
      end
      if (spm_go && is_lock)
        lock_value_ff <= store_data_register_pair_ff[7:0];
    end
  end

  assign flash_op_start            = start_ff;
  assign flash_op_erase            = erase_ff;
  assign flash_page_addr           = page_ff;
  assign boot_lock_bit_set         = lock_set_ff;
  assign boot_lock_value           = lock_value_ff;
  assign rww_section_read_reenable = rww_ff;

  // Stall the core only while the busy page sits in the non-read-while-write area
  wire no_read_while_write_section_hit = ({{(16-PG_W){1'b0}}, page_ff} >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
  assign cpu_stall = (state_ff == FSP_BUSY) && no_read_while_write_section_hit;

  // ==========================================================================
  // Temporary page buffer
  fsp_page_buf #(
    .AW         (PAGE_WORD_BITS),
    .DW         (16)
  ) u_page_buf (
    .clk        (clk),
    .wr_en      (buf_we),
    .wr_idx     (ptr_word),
    .wr_data    (store_data_register_pair_ff),
    .rd_idx     (flash_buf_idx),
    .rd_data_ff (flash_buf_data)
  );

  // ==========================================================================
  // Byte-wide program memory load; flash answers one cycle after the address
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_addr_ff    <= 15'h0000;
      byte_sel_ff   <= 1'b0;
      load_pend_ff  <= 1'b0;
      load_data_ff  <= 8'h00;
      load_valid_ff <= 1'b0;
    end
    else
    begin
      load_pend_ff  <= load_program_instruction;
      load_valid_ff <= load_pend_ff;
      if (load_program_instruction)
      begin
        rd_addr_ff  <= address_pointer_ff[15:1];
        byte_sel_ff <= address_pointer_ff[0];
      end
      if (load_pend_ff)
        load_data_ff <= byte_sel_ff ? flash_rd_data[15:8] : flash_rd_data[7:0];
    end
  end

  assign flash_rd_addr = rd_addr_ff;
  assign load_data     = load_data_ff;
  assign load_valid    = load_valid_ff;

endmodule

// *** testbench/fsp_ctrl_checker.sv ***
// Concurrent checks on the flash self-programming controller ports
`timescale 1ns/10ps
module fsp_ctrl_checker #(
  parameter int          PAGE_WORD_BITS  = 6,
  parameter logic [15:0] NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 16'h0070
) (
  // Clock and reset
  input wire logic                         clk,
  input wire logic                         rst,
  // Core side
  input wire logic                         store_program_instruction,
  input wire logic                         load_program_instruction,
  input wire logic                         load_valid,
  input wire logic                         cpu_stall,
  // Flash side
  input wire logic                         flash_op_start,
  input wire logic                         flash_op_done,
  input wire logic [15-PAGE_WORD_BITS-1:0] flash_page_addr,
  input wire logic                         boot_lock_bit_set,
  input wire logic                         rww_section_read_reenable
);
  logic high_page;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  assign high_page = flash_page_addr >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE;

  // ==========================================================================
  // Sequences
  sequence s_store_back;
    $past(store_program_instruction);
  endsequence
  sequence s_no_relaunch;
    !flash_op_start [*3];
  endsequence

  // ==========================================================================
  // Assertions
  a_start_has_store: assert property (flash_op_start |-> s_store_back)
    else $error("operation launched without a store");
  a_start_single: assert property (flash_op_start |=> s_no_relaunch)
    else $error("operation launched twice");
  a_lock_has_store: assert property (boot_lock_bit_set |-> s_store_back)
    else $error("lock pulse without a store");
  a_rww_has_store: assert property (rww_section_read_reenable |-> s_store_back)
    else $error("re-enable pulse without a store");
  a_stall_high_page: assert property (cpu_stall |-> high_page)
    else $error("stall on a page outside the protected section");
  a_stall_on_launch: assert property (flash_op_start && high_page |-> ##[0:1] cpu_stall)
    else $error("protected page launched without stall");
  a_stall_holds: assert property (cpu_stall && !flash_op_done |=> cpu_stall)
    else $error("stall dropped before the operation ended");
  a_load_answered: assert property (load_program_instruction |-> ##[1:3] load_valid)
    else $error("load not answered");
  a_load_single: assert property (load_valid |=> !load_valid)
    else $error("load answer longer than one cycle");
endmodule

bind fsp_ctrl fsp_ctrl_checker #(
  .PAGE_WORD_BITS (PAGE_WORD_BITS),
  .NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE(NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE)
) chk (.*);

// *** testbench/fsp_flash_model.sv ***
// Behavioural flash array: page operations, buffer sweep and word reads
`timescale 1ns/10ps
module fsp_flash_model #(
  parameter int DONE_DELAY = 20
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Operation handshake
  input  wire logic        flash_op_start,
  output logic             flash_op_done,
  // Page buffer sweep
  output logic [5:0]       flash_buf_idx,
  input  wire logic [15:0] flash_buf_data,
  // Word reads
  input  wire logic [14:0] flash_rd_addr,
  output logic [15:0]      flash_rd_data
);
  logic [15:0] cap_ff [64];
  logic [5:0]  idx_d_ff;
  logic        busy_ff;
  int          cnt_ff;

  // Combinational answer, so it is ready well before the cycle after
  assign flash_rd_data = {flash_rd_addr[7:0] ^ 8'h5a, flash_rd_addr[7:0]};

  // Buffer data lags the index by one cycle, hence the delayed index
  always_ff @(posedge clk)
  begin
    cap_ff[idx_d_ff] <= flash_buf_data;
    idx_d_ff <= flash_buf_idx;
    if (rst)
    begin
      busy_ff <= 1'b0;
      cnt_ff <= 0;
      flash_op_done <= 1'b0;
      flash_buf_idx <= 6'h00;
    end
    else
    begin
      flash_op_done <= busy_ff && cnt_ff == DONE_DELAY;
      if (flash_op_start)
      begin
        busy_ff <= 1'b1;
        cnt_ff <= 0;
        flash_buf_idx <= 6'h00;
      end
      else if (busy_ff)
      begin
        cnt_ff <= cnt_ff + 1;
        flash_buf_idx <= flash_buf_idx + 6'h01;
        if (cnt_ff == DONE_DELAY)
          busy_ff <= 1'b0;
      end
    end
  end
endmodule

// *** testbench/tb.sv ***
// Self-checking bench for the flash self-programming controller
`timescale 1ns/10ps
module tb;
  import fsp_pkg::*;
  logic        clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, store_program_instruction, load_program_instruction;
  logic        cpu_stall, load_valid, flash_op_start, flash_op_erase, flash_op_done;
  logic        boot_lock_bit_set, rww_section_read_reenable, seen;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [3:0]  s_axi_wstrb;
  logic [5:0]  flash_buf_idx;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, load_data, boot_lock_value, snap_ld, snap_lk;
  logic [8:0]  flash_page_addr;
  logic [14:0] flash_rd_addr, snap_ra;
  logic [15:0] flash_buf_data, flash_rd_data;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_d;
  int          fails, compares;
  logic [4:0]  row_pat [8] = '{5'h01, 5'h03, 5'h05, 5'h09, 5'h11, 5'h07, 5'h1f, 5'h02};
  logic [4:0]  row_arm [8] = '{5'h01, 5'h03, 5'h05, 5'h09, 5'h11, 5'h00, 5'h00, 5'h00};
  logic [15:0] pages [2] = '{16'h0103, 16'h3883};

  fsp_ctrl #(.NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE(16'h0070)) dut (.*);
  fsp_flash_model #(.DONE_DELAY(20)) fm (.*);

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ==========================================================================
  // Tasks
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic hang();
    check("wait bound", 1'b1, 1'b0);
    tally_and_finish();
  endtask
  // Ready judged mid-cycle, where it is settled
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    logic aw_hit, w_hit, b_hit;
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    for (int n = 0; n < 50; n++)
    begin
      @(negedge clk);
      aw_hit = s_axi_awvalid && s_axi_awready;
      w_hit = s_axi_wvalid && s_axi_wready;
      b_hit = s_axi_bvalid === 1'b1;
      rsp = s_axi_bresp;
      @(posedge clk);
      if (aw_hit)
        s_axi_awvalid <= 1'b0;
      if (w_hit)
        s_axi_wvalid <= 1'b0;
      if (b_hit)
        return;
    end
    hang();
  endtask
  task automatic axi_read(input logic [7:0] a);
    logic ar_hit, r_hit;
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    for (int n = 0; n < 50; n++)
    begin
      @(negedge clk);
      ar_hit = s_axi_arvalid && s_axi_arready;
      r_hit = s_axi_rvalid === 1'b1;
      rd_d = s_axi_rdata;
      rsp = s_axi_rresp;
      @(posedge clk);
      if (ar_hit)
        s_axi_arvalid <= 1'b0;
      if (r_hit)
        return;
    end
    hang();
  endtask
  task automatic pulse(input logic is_load);
    if (is_load)
      load_program_instruction <= 1'b1;
    else
      store_program_instruction <= 1'b1;
    @(posedge clk);
    load_program_instruction <= 1'b0;
    store_program_instruction <= 1'b0;
  endtask
  task automatic watch(input int sel);
    logic hit;
    seen = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      @(negedge clk);
      hit = sel == 0 ? flash_op_start : sel == 1 ? boot_lock_bit_set :
            sel == 2 ? rww_section_read_reenable : load_valid;
      if (hit === 1'b1 && seen === 1'b0)
      begin
        seen = 1'b1;
        snap_ld = load_data;
        snap_lk = boot_lock_value;
        snap_ra = flash_rd_addr;
      end
      @(posedge clk);
    end
  endtask
  task automatic arm_store(input logic [4:0] cmd, input int sel);
    axi_write(FSP_CTRL_OFS, 32'(cmd));
    pulse(1'b0);
    watch(sel);
  endtask
  task automatic do_op(input logic [4:0] cmd, input logic [15:0] ptr);
    axi_write(FSP_PTR_OFS, {16'h0000, ptr});
    arm_store(cmd, 0);
    check("op start", 1'b1, seen);
    axi_write(FSP_PTR_OFS, 32'h0000_0000);
    @(negedge clk);
    check("op page", ptr[15:7], flash_page_addr);
    check("op erase", cmd == FSP_CMD_ERASE, flash_op_erase);
    check("op stall", ptr[15:7] >= 9'h070, cpu_stall);
    @(posedge clk);
    axi_read(FSP_CTRL_OFS);
    check("ctrl busy", cmd, rd_d[4:0]);
    for (int n = 0; n <= 60; n++)
    begin
      @(negedge clk);
      if (flash_op_done === 1'b1)
        break;
      if (n == 60)
        hang();
    end
    repeat (2) @(posedge clk);
    axi_read(FSP_CTRL_OFS);
    check("ctrl done", 5'h00, rd_d[4:0]);
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    fails = 0;
    compares = 0;
    rst = 1'b1;
    s_axi_awvalid = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_wvalid = 1'b0;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hf;
    s_axi_bready = 1'b1;
    s_axi_arvalid = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_rready = 1'b1;
    store_program_instruction = 1'b0;
    load_program_instruction = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    for (int i = 0; i < 4; i++)
    begin
      axi_read(8'(i * 4));
      check("reset value", 32'h0000_0000, rd_d);
    end
    // Ordinary cases: the five accepted patterns armed, then left to time out; three other patterns not armed
    for (int i = 0; i < 8; i++)
    begin
      axi_write(FSP_CTRL_OFS, 32'(row_pat[i]));
      axi_read(FSP_CTRL_OFS);
      check("ctrl armed", row_arm[i], rd_d[4:0]);
      repeat (6) @(posedge clk);
      axi_read(FSP_CTRL_OFS);
      check("ctrl timeout", 5'h00, rd_d[4:0]);
    end
    axi_write(FSP_CTRL_OFS, 32'(FSP_CMD_WRITE));
    repeat (6) @(posedge clk);
    pulse(1'b0);
    watch(0);
    check("late store", 1'b0, seen);
    // Low page then protected page; erase and write name the same page
    for (int p = 0; p < 2; p++)
    begin
      axi_write(FSP_DATA_OFS, {16'h0000, pages[p] ^ 16'h5a5a});
      axi_write(FSP_PTR_OFS, {16'h0000, pages[p]});
      arm_store(FSP_CMD_FILL, 0);
      axi_read(FSP_CTRL_OFS);
      check("fill clears", 5'h00, rd_d[4:0]);
      do_op(FSP_CMD_ERASE, pages[p]);
      do_op(FSP_CMD_WRITE, pages[p]);
      check("buffer word", pages[p] ^ 16'h5a5a, fm.cap_ff[1]);
    end
    axi_write(FSP_DATA_OFS, 32'h0000_12a5);
    axi_write(FSP_PTR_OFS, 32'h0000_ffff);
    arm_store(FSP_CMD_LOCK, 1);
    check("lock pulse", 1'b1, seen);
    check("lock value", 8'ha5, snap_lk);
    arm_store(FSP_CMD_RWW, 2);
    check("rww pulse", 1'b1, seen);
    for (int b = 2; b < 4; b++)
    begin
      axi_write(FSP_PTR_OFS, 32'(b));
      pulse(1'b1);
      watch(3);
      check("load addr", 15'h0001, snap_ra);
      check("load byte", b == 3 ? 8'h5b : 8'h01, snap_ld);
    end
    axi_write(8'h10, 32'h0000_0001);
    check("unmapped wr", FSP_RESP_SLVERR, rsp);
    axi_read(8'h10);
    check("unmapped rd", FSP_RESP_SLVERR, rsp);
    check("unmapped data", 32'h0000_0000, rd_d);
    tally_and_finish();
  end
endmodule
